// ### src/lpm_consts.svh
/*
 Timing counts, field positions and reset values for the low power mode
 controller. Assumes mclk at 125 MHz.
*/
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_CLK_PERIOD_NS 8
`define LPM_SETTLE_TIME_NS 1000
`define LPM_SETTLE_CYCLES ((`LPM_SETTLE_TIME_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_DIV_FAST 4
`define LPM_DIV_SLOW 32
`define LPM_RAM_VALID_BIT 3
`define LPM_IE_BIT 0
`define LPM_ADDR_CTRL 32'h0000_0000
`define LPM_ADDR_STATUS 32'h0000_0004
`define LPM_ADDR_IRQ 32'h0000_0008
`define LPM_ADDR_SETTLE 32'h0000_000c
`define LPM_CTRL_RESET 32'h0000_0000
`define LPM_IRQ_WIDTH 6
`endif

// ### src/lpm_pkg.sv
/*
 Types for the low power mode controller.
 Assumes the constants header is included by users that need numbers.
*/
package lpm_pkg;
  typedef enum logic [1:0] {
    LPM_ACTIVE = 2'b00,
    LPM_STANDBY = 2'b01,
    LPM_STOP = 2'b11,
    LPM_WAKE = 2'b10
  } lpm_mode_t;

  typedef struct packed {
    logic standby_instruction;
    logic stop_instruction;
    logic return_from_interrupt_instruction;
    logic interrupt_taken;
  } lpm_cpu_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_run;
    logic cpu_reset;
    logic periph_reset;
    logic pin_hiz;
    logic restart_at_zero;
  } lpm_ctl_t;
endpackage : lpm_pkg

// ### src/lpm_clk_div.sv
/*
 System clock divider: divides by 4 or 32 as the select level dictates.
 Assumes the select level is stable while the divider is being restarted.
*/
`timescale 1ns/10ps
`include "lpm_consts.svh"
module lpm_clk_div
  import lpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic run,
  input wire logic div_sel,
  output logic tick,
  output logic ratio_fast
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
    logic fast;
  } lpm_div_st_t;
  lpm_div_st_t st, next_st;
  logic [4:0] last;

  always_comb begin
    next_st = st;
    last = st.fast ? 5'(`LPM_DIV_FAST - 1) : 5'(`LPM_DIV_SLOW - 1);
    next_st.tick = 1'b0;
    if (restart) begin
      // The ratio is latched only here, so a moving pin cannot glitch the clock.
      next_st.fast = div_sel;
      next_st.cnt = 5'h00;
    end else if (run) begin
      if (st.cnt == last) begin
        next_st.cnt = 5'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{cnt: 5'h00, tick: 1'b0, fast: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
  assign ratio_fast = st.fast;
endmodule : lpm_clk_div

// ### src/lpm_settle_timer.sv
/*
 Counts the oscillator settle time while a wake source is held.
 Assumes the count runs only while the wake input stays asserted.
*/
`timescale 1ns/10ps
`include "lpm_consts.svh"
module lpm_settle_timer
  import lpm_pkg::*;
#(
  parameter int SETTLE_CYCLES = `LPM_SETTLE_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hold,
  output logic done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic done;
  } lpm_tmr_st_t;
  lpm_tmr_st_t st, next_st;

  always_comb begin
    next_st = st;
    if (!hold) begin
      next_st.cnt = 16'h0000;
      next_st.done = 1'b0;
    end else if (st.cnt >= 16'(SETTLE_CYCLES - 1)) begin
      next_st.done = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{cnt: 16'h0000, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule : lpm_settle_timer

// ### src/lpm_ctrl.sv
/*
 Operating mode controller: active, standby and stop, with the register view
 over AHB-Lite. Assumes the CPU core pulses its instruction strobes for one
 mclk cycle and that mclk is the system oscillator, gated here via osc_run.
*/
// The address map and register access over AHB-Lite were decided locally.
// Behaviour
// - Active mode clocks everything from oscillator
// - Standby gates CPU clock, keeps oscillator
// - Standby keeps interrupts, timers, serial running
// - Standby entered only from active
// - Standby left by reset or interrupt
// - Interrupt wake resumes after standby instruction
// - Service wake interrupt only if enabled
// - Stop instruction halts oscillator, keeps RAM
// - Stop floats ports; standby holds them
// - Stop exit restarts at address zero
// - RAM kept; CPU registers undefined after stop
// - RAM valid cleared on reset, set by cancel
// - Stop cancel ignored outside stop mode
// - Reset is asynchronous in any state
// - Pending unmasked interrupt turns instruction into no-op; here only while the global enable is clear
// - Select pin picks divide by 4 or 32
// - Interrupt entry clears enable; return sets it
// - Stop resets peripherals and pin functions
`timescale 1ns/10ps
`include "lpm_consts.svh"
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int SETTLE_CYCLES = `LPM_SETTLE_CYCLES,
  parameter int IRQ_WIDTH = `LPM_IRQ_WIDTH
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire lpm_cpu_req_t cpu_req,
  input wire logic [IRQ_WIDTH-1:0] irq_flags,
  input wire logic [IRQ_WIDTH-1:0] irq_masks,
  input wire logic stop_cancel_input_b,
  input wire logic div_sel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output lpm_ctl_t ctl,
  output lpm_mode_t mode,
  output logic sys_tick,
  output logic global_interrupt_enable,
  output logic ram_valid_flag,
  output logic irq_service,
  output logic cpu_regs_invalid
);
  typedef struct packed {
    lpm_mode_t mode;
    logic ie;
    logic ram_valid;
    logic from_stop;
    logic div_restart;
    logic service;
    logic regs_invalid;
    logic wake_pending;
    logic ph_valid;
    logic ph_write;
    logic ph_hit;
    logic [3:0] ph_addr;
    logic [31:0] rdata;
    lpm_ctl_t ctl;
  } lpm_st_t;

  lpm_st_t st, next_st;
  logic any_pending;
  logic cancel_done;
  logic cancel_hold;
  logic [31:0] rd_mux;
  logic div_tick;
  logic ratio_fast;

  // Only a pending, unmasked request counts; masks are active high.
  assign any_pending = |(irq_flags & ~irq_masks);
  assign cancel_hold = (st.mode == LPM_STOP) && !stop_cancel_input_b;

  lpm_settle_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .mclk(mclk),
    .rst_b(rst_b),
    .hold(cancel_hold),
    .done(cancel_done)
  );

  lpm_clk_div u_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .restart(st.div_restart),
    .run(st.ctl.osc_run),
    .div_sel(div_sel),
    .tick(div_tick),
    .ratio_fast(ratio_fast)
  );

  function automatic lpm_ctl_t ctl_for(input lpm_mode_t m);
    lpm_ctl_t c;
    c = '0;
    case (m)
      LPM_ACTIVE: begin
        c.cpu_clk_en = 1'b1;
        c.periph_clk_en = 1'b1;
        c.osc_run = 1'b1;
      end
      LPM_STANDBY: begin
        c.cpu_clk_en = 1'b0;
        c.periph_clk_en = 1'b1;
        c.osc_run = 1'b1;
        c.pin_hiz = 1'b0;
      end
      LPM_STOP: begin
        c.osc_run = 1'b0;
        c.cpu_reset = 1'b1;
        c.periph_reset = 1'b1;
        c.pin_hiz = 1'b1;
      end
      LPM_WAKE: begin
        c.osc_run = 1'b1;
        c.cpu_reset = 1'b1;
        c.periph_reset = 1'b1;
        c.restart_at_zero = 1'b1;
      end
      default: begin
        c.osc_run = 1'b1;
      end
    endcase
    return c;
  endfunction : ctl_for

  // Read data is picked from the address phase so that it stands in the data phase.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `LPM_ADDR_CTRL: begin
        rd_mux[`LPM_IE_BIT] = st.ie;
      end
      `LPM_ADDR_STATUS: begin
        rd_mux[1:0] = st.mode;
        rd_mux[2] = ratio_fast;
        rd_mux[`LPM_RAM_VALID_BIT] = st.ram_valid;
        rd_mux[4] = st.regs_invalid;
      end
      `LPM_ADDR_IRQ: begin
        rd_mux[IRQ_WIDTH-1:0] = irq_flags & ~irq_masks;
      end
      `LPM_ADDR_SETTLE: begin
        rd_mux = 32'(SETTLE_CYCLES);
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.div_restart = 1'b0;
    next_st.service = 1'b0;
    // Bus address phase; the slave never stalls, so hreadyout stays high.
    next_st.ph_valid = hsel && hready && htrans[1];
    if (hsel && hready) begin
      next_st.ph_write = hwrite;
      next_st.ph_addr = haddr[3:0];
      // Addresses outside the four words are unmapped and must not alias.
      next_st.ph_hit = haddr[31:4] == 28'h000_0000;
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      next_st.rdata = rd_mux;
    end
    if (st.ph_valid && st.ph_write && st.ph_hit && st.ph_addr == 4'h0) begin
      next_st.ie = hwdata[`LPM_IE_BIT];
    end
    if (st.ph_valid && st.ph_write && st.ph_hit && st.ph_addr == 4'h4) begin
      // Software acknowledges the post-stop state by writing a one.
      if (hwdata[4]) begin
        next_st.regs_invalid = 1'b0;
      end
    end
    // Interrupt entry and return adjust the global enable.
    if (cpu_req.interrupt_taken) begin
      next_st.ie = 1'b0;
    end else if (cpu_req.return_from_interrupt_instruction) begin
      next_st.ie = 1'b1;
    end
    case (st.mode)
      LPM_ACTIVE: begin
        if (st.wake_pending) begin
          // Resume after the standby instruction, servicing only when enabled.
          next_st.wake_pending = 1'b0;
          next_st.service = st.ie && any_pending;
        end
        if (cpu_req.stop_instruction || cpu_req.standby_instruction) begin
          if (!st.ie && any_pending) begin
            next_st.mode = LPM_ACTIVE;
          end else if (cpu_req.stop_instruction) begin
            next_st.mode = LPM_STOP;
            next_st.regs_invalid = 1'b1;
          end else begin
            next_st.mode = LPM_STANDBY;
          end
        end
      end
      LPM_STANDBY: begin
        if (any_pending) begin
          next_st.mode = LPM_ACTIVE;
          next_st.wake_pending = 1'b1;
        end
      end
      LPM_STOP: begin
        if (cancel_done && cancel_hold) begin
          next_st.mode = LPM_WAKE;
          next_st.ram_valid = 1'b1;
          next_st.div_restart = 1'b1;
        end
      end
      LPM_WAKE: begin
        // Held until the cancel input is released, so the CPU restarts cleanly.
        if (stop_cancel_input_b) begin
          next_st.mode = LPM_ACTIVE;
        end
      end
      default: begin
        next_st.mode = LPM_ACTIVE;
      end
    endcase
    next_st.ctl = ctl_for(next_st.mode);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // Reset cancels any mode and clears the RAM valid flag.
      st.mode <= LPM_WAKE;
      st.ie <= 1'b0;
      st.ram_valid <= 1'b0;
      st.from_stop <= 1'b0;
      st.div_restart <= 1'b1;
      st.service <= 1'b0;
      st.regs_invalid <= 1'b0;
      st.wake_pending <= 1'b0;
      st.ph_valid <= 1'b0;
      st.ph_write <= 1'b0;
      st.ph_hit <= 1'b0;
      st.ph_addr <= 4'h0;
      st.rdata <= 32'h0000_0000;
      st.ctl <= '{osc_run: 1'b1, cpu_reset: 1'b1, periph_reset: 1'b1,
                 restart_at_zero: 1'b1, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ctl = st.ctl;
  assign mode = st.mode;
  assign sys_tick = div_tick;
  assign global_interrupt_enable = st.ie;
  assign ram_valid_flag = st.ram_valid;
  assign irq_service = st.service;
  assign cpu_regs_invalid = st.regs_invalid;
endmodule : lpm_ctrl

// ### testbench/lpm_ctrl_sva.sv
/* Port checker for the mode controller.
   Assumes the single clock mclk and that div_sel is held steady. */
`timescale 1ns/10ps
module lpm_ctrl_sva
  import lpm_pkg::*;
#(
  parameter int IRQ_WIDTH = 6
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire lpm_cpu_req_t cpu_req,
  input wire logic [IRQ_WIDTH-1:0] irq_flags,
  input wire logic [IRQ_WIDTH-1:0] irq_masks,
  input wire logic stop_cancel_input_b,
  input wire logic div_sel,
  input wire lpm_ctl_t ctl,
  input wire lpm_mode_t mode,
  input wire logic sys_tick,
  input wire logic global_interrupt_enable,
  input wire logic ram_valid_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic act = mode == LPM_ACTIVE;
  wire logic veto = !global_interrupt_enable && |(irq_flags & ~irq_masks);
  sequence fast_run_s;
    (sys_tick && div_sel && act) ##1 act [*3];
  endsequence
  stby_entry_a: assert property (act && cpu_req.standby_instruction && !veto |=>
    mode == LPM_STANDBY) else $error("standby not entered");
  stop_entry_a: assert property (act && cpu_req.stop_instruction && !veto |=>
    mode == LPM_STOP && !ctl.osc_run && ctl.pin_hiz && ctl.cpu_reset && ctl.periph_reset)
    else $error("stop not entered");
  nop_a: assert property (act && veto && (cpu_req.stop_instruction ||
    cpu_req.standby_instruction) |=> act) else $error("vetoed request acted");
  active_clk_a: assert property (act |-> ctl.cpu_clk_en && ctl.periph_clk_en &&
    ctl.osc_run) else $error("active clocks off");
  stby_clk_a: assert property (mode == LPM_STANDBY |-> !ctl.cpu_clk_en &&
    ctl.periph_clk_en && ctl.osc_run && !ctl.pin_hiz) else $error("standby clocks wrong");
  stby_wake_a: assert property (mode == LPM_STANDBY && |(irq_flags & ~irq_masks) |=>
    act) else $error("standby did not wake");
  cancel_ign_a: assert property (act && !stop_cancel_input_b |=> mode != LPM_WAKE &&
    $stable(ram_valid_flag)) else $error("cancel acted outside stop");
  stop_hold_a: assert property (mode == LPM_STOP && stop_cancel_input_b |=>
    mode == LPM_STOP) else $error("stop left early");
  stop_exit_a: assert property (mode == LPM_WAKE && $past(mode) == LPM_STOP |->
    ram_valid_flag && ctl.restart_at_zero) else $error("stop exit wrong");
  tick_fast_a: assert property (fast_run_s |=> sys_tick) else $error("tick period wrong");
endmodule : lpm_ctrl_sva

bind lpm_ctrl lpm_ctrl_sva #(.IRQ_WIDTH(IRQ_WIDTH)) sva_u (.mclk, .rst_b, .cpu_req,
  .irq_flags, .irq_masks, .stop_cancel_input_b, .div_sel, .ctl, .mode, .sys_tick,
  .global_interrupt_enable, .ram_valid_flag);

// ### testbench/lpm_cpu_model.sv
/* CPU core stand-in: turns a one-cycle op code into instruction strobes.
   Assumes op is held for exactly one mclk cycle. */
`timescale 1ns/10ps
module lpm_cpu_model
  import lpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] op,
  input wire logic irq_service,
  output lpm_cpu_req_t cpu_req
);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_req <= '0;
    end else begin
      cpu_req.standby_instruction <= op == 2'h1;
      cpu_req.stop_instruction <= op == 2'h2;
      cpu_req.return_from_interrupt_instruction <= op == 2'h3;
      // Handler entry follows the service request one mclk cycle later, as a real core would.
      cpu_req.interrupt_taken <= irq_service;
    end
  end
endmodule : lpm_cpu_model

// ### testbench/testbench.sv
/* Self-checking bench for the mode controller.
   Assumes a short settle count so that stop exits stay brief. */
`timescale 1ns/10ps
`include "lpm_consts.svh"
module testbench import lpm_pkg::*;;
  localparam int SETTLE = 4;
  logic mclk = 1'b0, rst_b = 1'b0, hwrite = 1'b0, hsel = 1'b0, cancel_b = 1'b1;
  logic div_sel = 1'b1;
  logic [1:0] op = 2'h0, htrans = 2'h0;
  logic [5:0] irq_flags = 6'h0, irq_masks = 6'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, sys_tick, ie, ram_valid, irq_service, regs_inv;
  lpm_ctl_t ctl;
  lpm_mode_t mode;
  lpm_cpu_req_t cpu_req;
  int fails = 0, checks = 0, cycles = 0;
  lpm_cpu_model cpu_u (.mclk, .rst_b, .op, .irq_service, .cpu_req);
  lpm_ctrl #(.SETTLE_CYCLES(SETTLE)) dut_u (.mclk, .rst_b, .cpu_req, .irq_flags, .irq_masks,
    .stop_cancel_input_b(cancel_b), .div_sel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hsel, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ctl, .mode, .sys_tick,
    .global_interrupt_enable(ie), .ram_valid_flag(ram_valid), .irq_service,
    .cpu_regs_invalid(regs_inv));
  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Read data stands in the data phase and is taken at its closing edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic issue(input logic [1:0] o);
    op <= o;
    @(posedge mclk);
    op <= 2'h0;
    tick(2);
  endtask : issue
  task automatic wait_mode(input lpm_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 200) begin
      @(posedge mclk);
      n++;
    end
    cmp(32'(mode), 32'(m));
  endtask : wait_mode
  task automatic t_reset();
    cmp(32'(mode), 32'(LPM_ACTIVE));
    bus(1'b0, `LPM_ADDR_STATUS, 32'h0);
    cmp(rd[3:0], 4'h4);
    bus(1'b0, `LPM_ADDR_CTRL, 32'h0);
    cmp(rd[0], 1'b0);
    bus(1'b1, 32'h0000_0040, 32'h1);
    bus(1'b0, 32'h0000_0040, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, `LPM_ADDR_CTRL, 32'h0);
    cmp(rd, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_cancel();
    cancel_b <= 1'b0;
    tick(SETTLE + 4);
    cmp(32'(mode), 32'(LPM_ACTIVE));
    cmp(ram_valid, 1'b0);
    cancel_b <= 1'b1;
    tick(1);
    $display("cancel test done");
  endtask : t_cancel
  task automatic t_standby();
    bus(1'b1, `LPM_ADDR_CTRL, 32'h1);
    issue(2'h1);
    cmp(32'(mode), 32'(LPM_STANDBY));
    cmp({ctl.cpu_clk_en, ctl.osc_run}, 2'h1);
    tick(3);
    irq_flags <= 6'h01;
    wait_mode(LPM_ACTIVE);
    tick(4);
    irq_flags <= 6'h00;
    bus(1'b0, `LPM_ADDR_CTRL, 32'h0);
    cmp(rd[0], 1'b0);
    issue(2'h3);
    bus(1'b0, `LPM_ADDR_CTRL, 32'h0);
    cmp(rd[0], 1'b1);
    $display("standby test done");
  endtask : t_standby
  task automatic t_nop();
    bus(1'b1, `LPM_ADDR_CTRL, 32'h0);
    irq_flags <= 6'h04;
    issue(2'h2);
    cmp(32'(mode), 32'(LPM_ACTIVE));
    issue(2'h1);
    cmp(32'(mode), 32'(LPM_ACTIVE));
    irq_masks <= 6'h04;
    $display("nop test done");
  endtask : t_nop
  task automatic t_stop();
    issue(2'h2);
    cmp(32'(mode), 32'(LPM_STOP));
    cmp({ctl.osc_run, ctl.pin_hiz}, 2'h1);
    cancel_b <= 1'b0;
    tick(SETTLE + 4);
    cmp(32'(mode), 32'(LPM_WAKE));
    cmp(ctl.restart_at_zero, 1'b1);
    cancel_b <= 1'b1;
    wait_mode(LPM_ACTIVE);
    cmp({ram_valid, regs_inv}, 2'h3);
    $display("stop test done");
  endtask : t_stop
  task automatic t_areset();
    issue(2'h1);
    #3 rst_b = 1'b0;
    #1 cmp(32'(mode), 32'(LPM_WAKE));
    cmp({ram_valid, ie}, 2'h0);
    @(posedge mclk);
    rst_b <= 1'b1;
    wait_mode(LPM_ACTIVE);
    $display("async reset test done");
  endtask : t_areset
  initial begin
    tick(6);
    rst_b <= 1'b1;
    tick(2);
    t_reset();
    t_cancel();
    t_standby();
    t_nop();
    t_stop();
    t_areset();
    test_done();
  end
endmodule : testbench
